// File: rtl/pmudl_mem.sv
// Purpose: Single port store for coefficients and corrected codes
// Assumes: One access per cycle, read data valid one cycle after address
// Notes: Array has no reset; contents are written by the default sweep
`timescale 1ns/10ps
module pmudl_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Access
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [WIDTH-1:0] i_wdata,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem [0:DEPTH-1];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule // pmudl_mem

// File: rtl/pmudl_pkg.sv
// Purpose: Constants for the measure channel DAC load control block
// Assumes: Four channels, five level DACs each, eight range slots per DAC
// Notes: Slot 7 is the voltage range slot, slots 0..4 are current ranges
package pmudl_pkg;
  localparam int NUM_CH = 4;
  localparam int NUM_DAC = 5;
  localparam int CODE_W = 16;
  localparam int CFG_W = 22;
  localparam int ADDR_W = 8;
  // Write kinds on the command port
  localparam logic [2:0] KIND_SYSCTL = 3'h0;
  localparam logic [2:0] KIND_CHANCFG = 3'h1;
  localparam logic [2:0] KIND_GAIN = 3'h2;
  localparam logic [2:0] KIND_OFFSET = 3'h3;
  localparam logic [2:0] KIND_INPUT = 3'h4;
  localparam logic [2:0] KIND_OFFDAC = 3'h5;
  // DAC indexes within a channel
  localparam logic [2:0] DAC_FORCE = 3'h0;
  localparam logic [2:0] DAC_LOW_CLAMP = 3'h1;
  localparam logic [2:0] DAC_HIGH_CLAMP = 3'h2;
  localparam logic [2:0] DAC_LOW_COMPARE = 3'h3;
  localparam logic [2:0] DAC_HIGH_COMPARE = 3'h4;
  localparam logic [2:0] VOLT_SLOT = 3'h7;
  // Reset values
  localparam logic [15:0] GAIN_RESET = 16'hffff;
  localparam logic [15:0] OFFSET_RESET = 16'h8000;
  localparam logic [15:0] MIDSCALE = 16'h8000;
  localparam logic [15:0] OFFDAC_RESET = 16'ha492;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_FULL = 16'hffff;
  localparam logic [21:0] SYSCTL_RESET = 22'h000020;
  localparam logic [21:0] CHANCFG_RESET = 22'h01e060;
  // Channel config fields
  localparam int CFG_FORCE_LSB = 19;
  localparam int CFG_RANGE_LSB = 15;
  localparam int CFG_THERMAL_SHUTDOWN_BIT = 5;
  // Host writable bits; alarm bits, reserved bit and unused bits are kept
  localparam logic [21:0] CHANCFG_WR_MASK = 22'h3bff80;
  localparam logic [1:0] FORCE_FV = 2'h0;
  localparam logic [1:0] FORCE_FI = 2'h1;
  localparam logic [1:0] FORCE_HIGHZ_V = 2'h2;
  localparam logic [1:0] FORCE_HIGHZ_I = 2'h3;
endpackage

// File: rtl/pmudl_top.sv
// Purpose: Calibration engine and DAC load strobe for four measure channels
// Assumes: Command port writes are synchronous to i_clk; host honours o_wr_ready
// Notes: One operation at a time; back pressure keeps writes in arrival order
`timescale 1ns/10ps
module pmudl_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Command port
  input wire logic i_wr_valid,
  input wire logic [2:0] i_wr_kind,
  input wire logic [1:0] i_wr_chan,
  input wire logic [2:0] i_wr_dac,
  input wire logic [2:0] i_wr_slot,
  input wire logic [21:0] i_wr_data,
  output logic o_wr_ready,
  // Device state
  output logic [21:0] o_system_control,
  output logic [pmudl_pkg::NUM_CH*pmudl_pkg::CFG_W-1:0] o_channel_config,
  output logic [pmudl_pkg::NUM_CH-1:0] o_force_highz,
  output logic [15:0] o_offset_dac,
  output logic [pmudl_pkg::NUM_CH*pmudl_pkg::NUM_DAC*16-1:0] o_dac_code
);
  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_CRD, ST_CALC, ST_CWR, ST_LRD, ST_LWR
  } pmudl_state_t;

  pmudl_state_t state, next_state;
  logic [7:0] init_cnt;
  logic [7:0] cur_addr;
  logic [15:0] cur_code;
  logic [15:0] corr;
  logic [1:0] load_ch;
  logic [2:0] load_idx;
  logic [7:0] mem_addr;
  logic gain_we, off_we, corr_we;
  logic [15:0] gain_rd, off_rd, corr_rd, gain_wd, off_wd, corr_wd;
  logic acc;
  logic auto_load;

  function automatic logic [15:0] dac_default(input logic [2:0] dac);
    case (dac)
      pmudl_pkg::DAC_FORCE: dac_default = pmudl_pkg::MIDSCALE;
      pmudl_pkg::DAC_HIGH_CLAMP, pmudl_pkg::DAC_HIGH_COMPARE: dac_default = pmudl_pkg::CODE_FULL;
      default: dac_default = pmudl_pkg::CODE_ZERO;
    endcase
  endfunction

  function automatic logic is_highz(input logic [21:0] cfg);
    is_highz = cfg[pmudl_pkg::CFG_FORCE_LSB+1];
  endfunction

  // Slot called by the current mode; clamps work in the opposite quantity
  function automatic logic [2:0] sel_slot(input logic [21:0] cfg, input logic [2:0] dac);
    logic volt;
    volt = (cfg[pmudl_pkg::CFG_FORCE_LSB +: 2] == pmudl_pkg::FORCE_FV) ||
           (cfg[pmudl_pkg::CFG_FORCE_LSB +: 2] == pmudl_pkg::FORCE_HIGHZ_V);
    if ((dac == pmudl_pkg::DAC_LOW_CLAMP) || (dac == pmudl_pkg::DAC_HIGH_CLAMP)) begin
      volt = !volt;
    end
    sel_slot = volt ? pmudl_pkg::VOLT_SLOT : cfg[pmudl_pkg::CFG_RANGE_LSB +: 3];
  endfunction

  // Gain as (m+1)/65536 so full scale is unity; offset relative to midscale
  function automatic logic [15:0] corr_calc(input logic [15:0] x, input logic [15:0] m,
                                             input logic [15:0] c);
    logic [32:0] prod;
    logic [17:0] sum;
    prod = {17'h00000, x} * {16'h0000, 1'b0, m} + {17'h00000, x};
    sum = {1'b0, prod[32:16]} + {2'h0, c} - {2'h0, pmudl_pkg::MIDSCALE};
    if (sum[17]) begin
      corr_calc = pmudl_pkg::CODE_ZERO;
    end else if (sum[16]) begin
      corr_calc = pmudl_pkg::CODE_FULL;
    end else begin
      corr_calc = sum[15:0];
    end
  endfunction

  function automatic logic [21:0] cfg_of(input logic [87:0] all, input logic [1:0] ch);
    cfg_of = all[ch*pmudl_pkg::CFG_W +: pmudl_pkg::CFG_W];
  endfunction

  assign acc = i_wr_valid && o_wr_ready;
  assign auto_load = (state == ST_CWR) && is_highz(cfg_of(o_channel_config, cur_addr[7:6])) &&
                     (cur_addr[5:3] <= pmudl_pkg::DAC_HIGH_CLAMP) &&
                     (cur_addr[2:0] == sel_slot(cfg_of(o_channel_config, cur_addr[7:6]),
                                                cur_addr[5:3]));

  always_comb begin
    next_state = state;
    case (state)
      ST_INIT: if (init_cnt == 8'hff) next_state = ST_IDLE;
      ST_IDLE: begin
        if (acc && (i_wr_kind == pmudl_pkg::KIND_INPUT)) next_state = ST_CRD;
        else if (acc && (i_wr_kind == pmudl_pkg::KIND_CHANCFG)) next_state = ST_LRD;
      end
      ST_CRD: next_state = ST_CALC;
      ST_CALC: next_state = ST_CWR;
      ST_CWR: next_state = ST_IDLE;
      ST_LRD: next_state = ST_LWR;
      ST_LWR: if (load_idx == pmudl_pkg::DAC_HIGH_COMPARE) next_state = ST_IDLE;
              else next_state = ST_LRD;
      default: next_state = ST_IDLE;
    endcase
  end

  // One shared address; the single sequencer never needs two at once
  always_comb begin
    case (state)
      ST_INIT: mem_addr = init_cnt;
      ST_IDLE: mem_addr = {i_wr_chan, i_wr_dac, i_wr_slot};
      ST_LRD, ST_LWR: mem_addr = {load_ch, load_idx,
                                  sel_slot(cfg_of(o_channel_config, load_ch), load_idx)};
      default: mem_addr = cur_addr;
    endcase
    gain_we = (state == ST_INIT) || (acc && (i_wr_kind == pmudl_pkg::KIND_GAIN));
    off_we = (state == ST_INIT) || (acc && (i_wr_kind == pmudl_pkg::KIND_OFFSET));
    corr_we = (state == ST_INIT) || (state == ST_CWR);
    gain_wd = (state == ST_INIT) ? pmudl_pkg::GAIN_RESET : i_wr_data[15:0];
    off_wd = (state == ST_INIT) ? pmudl_pkg::OFFSET_RESET : i_wr_data[15:0];
    corr_wd = (state == ST_INIT) ? dac_default(init_cnt[5:3]) : corr;
  end

  pmudl_mem #(.WIDTH(16), .DEPTH(256), .AW(8)) u_gain (
    .i_clk(i_clk), .i_rst(i_rst), .i_we(gain_we), .i_addr(mem_addr),
    .i_wdata(gain_wd), .o_rdata(gain_rd));
  pmudl_mem #(.WIDTH(16), .DEPTH(256), .AW(8)) u_offset (
    .i_clk(i_clk), .i_rst(i_rst), .i_we(off_we), .i_addr(mem_addr),
    .i_wdata(off_wd), .o_rdata(off_rd));
  // One corrected code per channel, DAC and range slot
  pmudl_mem #(.WIDTH(16), .DEPTH(256), .AW(8)) u_corr (
    .i_clk(i_clk), .i_rst(i_rst), .i_we(corr_we), .i_addr(mem_addr),
    .i_wdata(corr_wd), .o_rdata(corr_rd));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_INIT;
      init_cnt <= 8'h00;
      o_wr_ready <= 1'b0;
    end else begin
      state <= next_state;
      init_cnt <= (state == ST_INIT) ? init_cnt + 8'h01 : init_cnt;
      o_wr_ready <= (next_state == ST_IDLE);
    end
  end

  // Calibration engine
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cur_addr <= 8'h00;
      cur_code <= 16'h0000;
      corr <= 16'h0000;
    end else begin
      if (acc) begin
        cur_addr <= {i_wr_chan, i_wr_dac, i_wr_slot};
        cur_code <= i_wr_data[15:0];
      end
      if (state == ST_CALC) begin
        corr <= corr_calc(cur_code, gain_rd, off_rd);
      end
    end
  end

  // Host registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_system_control <= pmudl_pkg::SYSCTL_RESET;
      o_offset_dac <= pmudl_pkg::OFFDAC_RESET;
      o_channel_config <= {pmudl_pkg::NUM_CH{pmudl_pkg::CHANCFG_RESET}};
      o_force_highz <= '0;
      load_ch <= 2'h0;
    end else if (acc) begin
      if (i_wr_kind == pmudl_pkg::KIND_SYSCTL) o_system_control <= i_wr_data;
      if (i_wr_kind == pmudl_pkg::KIND_OFFDAC) o_offset_dac <= i_wr_data[15:0];
      if (i_wr_kind == pmudl_pkg::KIND_CHANCFG) begin
        // Alarm bits are device status and survive a config write
        o_channel_config[i_wr_chan*pmudl_pkg::CFG_W +: pmudl_pkg::CFG_W] <=
          (i_wr_data & pmudl_pkg::CHANCFG_WR_MASK) |
          (cfg_of(o_channel_config, i_wr_chan) & ~pmudl_pkg::CHANCFG_WR_MASK);
        o_force_highz[i_wr_chan] <= is_highz(i_wr_data);
        load_ch <= i_wr_chan;
      end
    end
  end

  // DAC registers: loaded by the config strobe or by high impedance auto update
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      load_idx <= 3'h0;
      for (int ch = 0; ch < pmudl_pkg::NUM_CH; ch++) begin
        for (int d = 0; d < pmudl_pkg::NUM_DAC; d++) begin
          o_dac_code[(ch*pmudl_pkg::NUM_DAC+d)*16 +: 16] <= dac_default(3'(d));
        end
      end
    end else begin
      if (state == ST_IDLE) load_idx <= 3'h0;
      if (state == ST_LWR) begin
        o_dac_code[({3'h0, load_ch}*5 + {2'h0, load_idx})*16 +: 16] <= corr_rd;
        load_idx <= load_idx + 3'h1;
      end
      if (auto_load) begin
        o_dac_code[({3'h0, cur_addr[7:6]}*5 + {2'h0, cur_addr[5:3]})*16 +: 16] <= corr;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_sysctl_reset_val: assert property ($fell(i_rst) |->
    o_system_control == pmudl_pkg::SYSCTL_RESET) else $error("sysctl reset value wrong");
  a_chancfg_reset_val: assert property ($fell(i_rst) |->
    o_channel_config[21:0] == 22'h01e060) else $error("channel config reset value wrong");
  a_dac_reset_val: assert property ($fell(i_rst) |->
    o_dac_code[15:0] == 16'h8000 && o_dac_code[47:32] == 16'hffff && o_offset_dac == 16'ha492)
    else $error("DAC reset value wrong");
  a_init_sweep_len: assert property ($fell(i_rst) |->
    !o_wr_ready [*8] ##0 (state == ST_INIT)) else $error("default sweep too short");
  a_gain_default: assert property (state == ST_INIT |-> gain_wd == 16'hffff &&
    off_wd == 16'h8000 && gain_we && off_we) else $error("coefficient defaults wrong");
  a_input_calc: assert property (acc && i_wr_kind == pmudl_pkg::KIND_INPUT |->
    ##3 corr_we && mem_addr == $past(mem_addr, 3)) else $error("corrected code not stored");
  a_load_strobe: assert property (acc && i_wr_kind == pmudl_pkg::KIND_CHANCFG |=>
    !o_wr_ready [*5] ##1 !o_wr_ready [*5] ##1 o_wr_ready) else $error("load sequence length wrong");
  a_highz_flag: assert property (acc && i_wr_kind == pmudl_pkg::KIND_CHANCFG |->
    ##1 o_force_highz[$past(i_wr_chan)] == $past(i_wr_data[20])) else $error("highz flag wrong");
  a_no_overlap: assert property (state != ST_IDLE |-> !o_wr_ready ||
    next_state == ST_IDLE) else $error("write accepted while busy");
  a_calc_sat: assert property (state == ST_CWR && $past(off_rd) == 16'hffff &&
    $past(gain_rd) == 16'hffff && $past(cur_code) == 16'hffff |-> corr == 16'hffff)
    else $error("saturation wrong");
  // Address and result both hold until the next accepted write
  a_auto_load_value: assert property (auto_load |=>
    o_dac_code[({3'h0, cur_addr[7:6]}*5 + {2'h0, cur_addr[5:3]})*16 +: 16] == corr)
    else $error("auto load value wrong");

  c_input_write: cover property (acc && i_wr_kind == pmudl_pkg::KIND_INPUT ##4 o_wr_ready);
  c_load_done: cover property (state == ST_LWR && load_idx == pmudl_pkg::DAC_HIGH_COMPARE);
  c_auto_load: cover property (auto_load);
  c_busy_stall: cover property (i_wr_valid && !o_wr_ready && state != ST_INIT);
endmodule // pmudl_top

// File: testbench/pmudl_host.sv
// Purpose: Host model issuing one command port write at a time
// Assumes: Bench calls send; fields change only at falling edges
// Notes: Released fields show the inverse of the last value, never stale data
`timescale 1ns/10ps
module pmudl_host (
  // Clock and handshake
  input wire logic i_clk,
  input wire logic i_ready,
  // Command port
  output logic o_wr_valid,
  output logic [2:0] o_wr_kind,
  output logic [1:0] o_wr_chan,
  output logic [2:0] o_wr_dac,
  output logic [2:0] o_wr_slot,
  output logic [21:0] o_wr_data,
  output int o_taken
);
  initial begin
    o_wr_valid = 1'b0;
    {o_wr_kind, o_wr_chan, o_wr_dac, o_wr_slot, o_wr_data} = '0;
    o_taken = 0;
  end
  // Bench orders writes: system control, offset DAC, then channels 1, 2 and 3 in turn
  task automatic send(input logic [2:0] kind, input logic [1:0] chan, input logic [2:0] dac,
                      input logic [2:0] slot, input logic [21:0] data);
    @(negedge i_clk);
    while (i_ready !== 1'b1) @(negedge i_clk);
    o_wr_valid = 1'b1;
    {o_wr_kind, o_wr_chan, o_wr_dac, o_wr_slot, o_wr_data} = {kind, chan, dac, slot, data};
    // Ready only falls after a take, so this edge takes the request
    @(posedge i_clk);
    o_taken = o_taken + 1;
    @(negedge i_clk);
    o_wr_valid = 1'b0;
    {o_wr_kind, o_wr_chan, o_wr_dac, o_wr_slot, o_wr_data} = ~{kind, chan, dac, slot, data};
    repeat (3) @(negedge i_clk);
    while (i_ready !== 1'b1) @(negedge i_clk);
    repeat (2) @(negedge i_clk);
  endtask
endmodule // pmudl_host

// File: testbench/tb_pmu_dac_load_control.sv
// Purpose: Self-checking bench for the measure channel DAC load control
// Assumes: Results are compared two ready-high cycles after each take
// Notes: Notes carry the take number they belong to; id 0 is the reset state
`timescale 1ns/10ps
module tb_pmu_dac_load_control;
  typedef struct {int id; int sel; logic [21:0] exp;} pmudl_note_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_valid, wr_ready;
  logic [2:0] wr_kind, wr_dac, wr_slot;
  logic [1:0] wr_chan;
  logic [21:0] wr_data, sysctl;
  logic [87:0] chancfg;
  logic [3:0] highz;
  logic [15:0] offdac;
  logic [319:0] dac_code;
  logic [31:0] lfsr = 32'hae4b4675;
  logic [15:0] xa, xb, y, x2;
  pmudl_note_t q[$];
  int fails = 0, checks_done = 0, nid = 0, seen = 0, hi_cnt = 0, cyc = 0, taken;
  always #4 clk = ~clk;
  pmudl_host host (.i_clk(clk), .i_ready(wr_ready), .o_wr_valid(wr_valid), .o_wr_kind(wr_kind),
    .o_wr_chan(wr_chan), .o_wr_dac(wr_dac), .o_wr_slot(wr_slot), .o_wr_data(wr_data),
    .o_taken(taken));
  pmudl_top uut (.i_clk(clk), .i_rst(rst), .i_wr_valid(wr_valid), .i_wr_kind(wr_kind),
    .i_wr_chan(wr_chan), .i_wr_dac(wr_dac), .i_wr_slot(wr_slot), .i_wr_data(wr_data),
    .o_wr_ready(wr_ready), .o_system_control(sysctl), .o_channel_config(chancfg),
    .o_force_highz(highz), .o_offset_dac(offdac), .o_dac_code(dac_code));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction
  // Scaled gain, offset about midscale, clipped to the code range
  function automatic logic [15:0] corr(logic [15:0] m, logic [15:0] c, logic [15:0] x);
    longint v;
    v = (((longint'(m) + 1) * longint'(x)) >>> 16) + longint'(c) - 32768;
    return (v < 0) ? 16'h0000 : (v > 65535) ? 16'hffff : v[15:0];
  endfunction
  function automatic logic [21:0] cfg(logic [1:0] f, logic [2:0] r);
    return (22'(f) << 19) | (22'(r) << 15) | 22'h000060;
  endfunction
  function automatic logic [21:0] get(int sel);
    if (sel < 20) return 22'(dac_code[sel*16 +: 16]);
    if (sel == 20) return sysctl;
    if (sel == 21) return 22'(offdac);
    if (sel < 26) return chancfg[(sel-22)*22 +: 22];
    return 22'(highz);
  endfunction
  task automatic note(int sel, logic [21:0] e);
    q.push_back('{nid, sel, e});
  endtask
  task automatic wr(logic [2:0] k, logic [1:0] c, logic [2:0] d, logic [2:0] s, logic [21:0] v);
    host.send(k, c, d, s, v);
    nid++;
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Monitor: a result has settled once ready has been high for two cycles
  always @(negedge clk) begin
    if (rst || wr_ready !== 1'b1 || taken != seen) begin
      hi_cnt = 0;
      seen = taken;
    end else begin
      hi_cnt++;
    end
    if (hi_cnt == 2) begin
      while (q.size() > 0 && q[0].id <= seen) begin
        checks_done++;
        if (get(q[0].sel) !== q[0].exp) begin
          fails++;
          $display("wrong value at %0t: got %h expected %h", $time, get(q[0].sel), q[0].exp);
        end
        void'(q.pop_front());
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    for (int c = 0; c < 4; c++) begin
      note(22 + c, 22'h01e060);
      note(c*5 + 0, 22'h008000);
      note(c*5 + 1, 22'h000000);
      note(c*5 + 2, 22'h00ffff);
      note(c*5 + 3, 22'h000000);
      note(c*5 + 4, 22'h00ffff);
    end
    note(20, 22'h000020);
    note(21, 22'h00a492);
    note(26, 22'h0);
    repeat (10) @(negedge clk);
    rst = 1'b0;
    // Monitor must see the reset state before the first write changes it
    wait (wr_ready === 1'b1);
    repeat (3) @(negedge clk);
    nid = 1;
    xa = rnd();
    note(20, {6'h15, xa});
    wr(pmudl_pkg::KIND_SYSCTL, 2'h0, 3'h0, 3'h0, {6'h15, xa});
    xa = rnd();
    note(21, 22'(xa));
    wr(pmudl_pkg::KIND_OFFDAC, 2'h0, 3'h0, 3'h0, 22'(xa));
    // Channel 1 keeps default coefficients, so corrected equals input
    xa = rnd();
    xb = rnd();
    y = rnd();
    note(5, 22'h008000);
    wr(pmudl_pkg::KIND_INPUT, 2'h1, pmudl_pkg::DAC_FORCE, 3'h7, 22'(xa));
    wr(pmudl_pkg::KIND_INPUT, 2'h1, pmudl_pkg::DAC_FORCE, 3'h3, 22'(xb));
    wr(pmudl_pkg::KIND_INPUT, 2'h1, pmudl_pkg::DAC_LOW_CLAMP, 3'h3, 22'(y));
    note(5, 22'(xa));
    note(6, 22'(y));
    note(23, cfg(pmudl_pkg::FORCE_FV, 3'h3));
    wr(pmudl_pkg::KIND_CHANCFG, 2'h1, 3'h0, 3'h0, cfg(pmudl_pkg::FORCE_FV, 3'h3));
    note(5, 22'(xb));
    wr(pmudl_pkg::KIND_CHANCFG, 2'h1, 3'h0, 3'h0, cfg(pmudl_pkg::FORCE_FI, 3'h3));
    // Channel 2 arithmetic and both saturation ends
    x2 = rnd();
    wr(pmudl_pkg::KIND_GAIN, 2'h2, pmudl_pkg::DAC_FORCE, 3'h7, 22'h007fff);
    wr(pmudl_pkg::KIND_OFFSET, 2'h2, pmudl_pkg::DAC_FORCE, 3'h7, 22'h008100);
    wr(pmudl_pkg::KIND_INPUT, 2'h2, pmudl_pkg::DAC_FORCE, 3'h7, 22'(x2));
    wr(pmudl_pkg::KIND_OFFSET, 2'h2, pmudl_pkg::DAC_HIGH_COMPARE, 3'h7, 22'h00ffff);
    wr(pmudl_pkg::KIND_INPUT, 2'h2, pmudl_pkg::DAC_HIGH_COMPARE, 3'h7, 22'h00ffff);
    wr(pmudl_pkg::KIND_OFFSET, 2'h2, pmudl_pkg::DAC_LOW_COMPARE, 3'h7, 22'h000000);
    wr(pmudl_pkg::KIND_INPUT, 2'h2, pmudl_pkg::DAC_LOW_COMPARE, 3'h7, 22'h000010);
    note(10, 22'(corr(16'h7fff, 16'h8100, x2)));
    note(14, 22'(corr(16'hffff, 16'hffff, 16'hffff)));
    note(13, 22'(corr(16'hffff, 16'h0000, 16'h0010)));
    wr(pmudl_pkg::KIND_CHANCFG, 2'h2, 3'h0, 3'h0, cfg(pmudl_pkg::FORCE_FV, 3'h3));
    // Channel 3 high impedance: force and clamps follow input writes at once
    note(25, cfg(pmudl_pkg::FORCE_HIGHZ_V, 3'h3));
    note(26, 22'h000008);
    wr(pmudl_pkg::KIND_CHANCFG, 2'h3, 3'h0, 3'h0, cfg(pmudl_pkg::FORCE_HIGHZ_V, 3'h3));
    xa = rnd();
    y = rnd();
    note(15, 22'(xa));
    wr(pmudl_pkg::KIND_INPUT, 2'h3, pmudl_pkg::DAC_FORCE, 3'h7, 22'(xa));
    note(16, 22'(y));
    wr(pmudl_pkg::KIND_INPUT, 2'h3, pmudl_pkg::DAC_LOW_CLAMP, 3'h3, 22'(y));
    note(19, 22'h00ffff);
    wr(pmudl_pkg::KIND_INPUT, 2'h3, pmudl_pkg::DAC_HIGH_COMPARE, 3'h7, 22'(rnd()));
    // All ones: reserved and alarm bits keep their values
    note(25, 22'h3bffe0);
    note(26, 22'h000008);
    wr(pmudl_pkg::KIND_CHANCFG, 2'h3, 3'h0, 3'h0, 22'h3fffff);
    repeat (4) @(negedge clk);
    if (q.size() != 0) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, q.size(), 0);
    end
    report_and_stop();
  end
endmodule // tb_pmu_dac_load_control
